//--- logic/stm_pkg.sv
// Shared constants, types and helpers for the stack and table address block.
package stm_pkg;

   // ****************************************
   // Word layout
   // ****************************************
   localparam int WORD_W = 48;
   localparam int ADDR_W = 16;
   localparam int IND_BIT = 42;
   localparam int INC_BIT = 33;
   localparam int DEC_BIT = 32;
   localparam int BRING_BIT = 23;
   localparam int HOLD_BIT = 22;
   localparam int XSEL_LO = 24;
   localparam int XSEL_W = 5;
   localparam logic [4:0] XSEL_NONE = 5'h00;
   localparam logic [4:0] XSEL_MEM_MAX = 5'h0f;
   localparam logic [4:0] XSEL_SP = 5'h10;
   localparam logic [4:0] XSEL_HP = 5'h11;

   // ****************************************
   // Register map and reset values
   // ****************************************
   localparam logic [3:0] REG_TOGGLES = 4'h0;
   localparam logic [3:0] REG_SET = 4'h1;
   localparam logic [3:0] REG_CLEAR = 4'h2;
   localparam logic [3:0] REG_SP = 4'h3;
   localparam logic [3:0] REG_HP = 4'h4;
   localparam logic [3:0] REG_DISPLAY = 4'h5;
   localparam logic [3:0] REG_STATUS = 4'h6;
   localparam int TG_STACK = 0;
   localparam int TG_TABLE = 1;
   localparam int TG_UP16 = 2;
   localparam int TG_DN16 = 3;
   localparam int TG_UP17 = 4;
   localparam int TG_DN17 = 5;
   localparam int ST_BUSY = 0;
   localparam int ST_ERR = 1;
   localparam logic [15:0] PTR_RESET = 16'h0000;
   localparam logic [15:0] ONE_BCD = 16'h0001;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      CLS_NONE = 2'h0,
      CLS_READ = 2'h1,
      CLS_STORE = 2'h2,
      CLS_EXEC = 2'h3
   } stm_class_type;

   typedef enum logic [8:0] {
      S_IDLE = 9'h001,
      S_WBACK = 9'h002,
      S_IND = 9'h004,
      S_BRING = 9'h008,
      S_DECIDE = 9'h010,
      S_XMOD = 9'h020,
      S_EXEC = 9'h040,
      S_HOLD = 9'h080,
      S_DONE = 9'h100
   } stm_state_type;

   typedef struct packed {
      logic req;
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] wdata;
   } stm_mem_type;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [ADDR_W-1:0] addr_of(input logic [WORD_W-1:0] w);
      return {w[21:18], w[15:12], w[9:6], w[3:0]};
   endfunction

   function automatic logic [WORD_W-1:0] put_addr(input logic [WORD_W-1:0] w,
                                                  input logic [ADDR_W-1:0] a);
      logic [WORD_W-1:0] r;
      r = w;
      r[21:18] = a[15:12];
      r[15:12] = a[11:8];
      r[9:6] = a[7:4];
      r[3:0] = a[3:0];
      return r;
   endfunction

   // Decimal add of two four-digit addresses, carry out of the top digit dropped.
   function automatic logic [ADDR_W-1:0] bcd_add(input logic [ADDR_W-1:0] a,
                                                 input logic [ADDR_W-1:0] b);
      logic [ADDR_W-1:0] r;
      logic [4:0] s;
      logic c;
      r = '0;
      c = 1'b0;
      for (int i = 0; i < 4; i++) begin
         s = 5'(a[4*i +: 4]) + 5'(b[4*i +: 4]) + 5'(c);
         c = (s > 5'h09);
         r[4*i +: 4] = c ? 4'(s - 5'h0a) : s[3:0];
      end
      return r;
   endfunction

endpackage

//--- logic/stm_step.sv
// Four-digit decimal step by one, up or down, wrapping at the ends.
`timescale 1ns/1ps
module stm_step
   import stm_pkg::*;
(
   // Operand
   input wire logic [ADDR_W-1:0] val,
   input wire logic down,
   // Result
   output logic [ADDR_W-1:0] res
);

   // ****************************************
   // Digit ripple
   // ****************************************
   always_comb begin
      logic run;
      run = 1'b1;
      res = val;
      for (int i = 0; i < 4; i++) begin
         if (run) begin
            if (down) begin
               res[4*i +: 4] = (val[4*i +: 4] == 4'h0) ? 4'h9 : 4'(val[4*i +: 4] - 4'h1);
               run = (val[4*i +: 4] == 4'h0);
            end else begin
               res[4*i +: 4] = (val[4*i +: 4] >= 4'h9) ? 4'h0 : 4'(val[4*i +: 4] + 4'h1);
               run = (val[4*i +: 4] >= 4'h9);
            end
         end
      end
   end

endmodule // stm_step

//--- logic/stm_index_bank.sv
// The two static index registers: stack pointer and hold pointer.
`timescale 1ns/1ps
module stm_index_bank
   import stm_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   // Write ports
   input wire logic sp_we,
   input wire logic [ADDR_W-1:0] sp_d,
   input wire logic hp_we,
   input wire logic [ADDR_W-1:0] hp_d,
   // Stored values
   output logic [ADDR_W-1:0] sp,
   output logic [ADDR_W-1:0] hp
);

   // ****************************************
   // Storage
   // ****************************************
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sp <= PTR_RESET;
         hp <= PTR_RESET;
      end else if (ce) begin
         if (sp_we) begin
            sp <= sp_d;
         end
         if (hp_we) begin
            hp <= hp_d;
         end
      end
   end

endmodule // stm_index_bank

//--- logic/stm_addr_seq.sv
// Operand address sequencer for stack mode and multi-table mode.
// How it works
// - Stack toggle settable, clearable, readable; enables stack mode.
// - Zero final address in stack mode means stack op.
// - Nonzero address or ineligible instruction runs normally.
// - Stack op address from stack pointer, index ignored.
// - Stack read uses pointer, then decrements it.
// - Stack store increments pointer, then uses it.
// - Stack execute fetch is a read, pointer decrements.
// - Executed stack op: read next word, store itself.
// - Final index step reads memory index, updates display.
// - Hold transfer sequenced at the closing step.
// - Table mode needs toggle plus an option bit.
// - Bring loads word at pointer, then steps it.
// - Bring count toggles exclusive; setting one clears other.
// - Hold stores word at hold pointer, then steps it.
// - Hold count toggles exclusive; setting one clears other.
// - Bring and hold bypass secondary register; both allowed.
// - Increment option writes instruction back, address plus one.
// - Decrement option writes instruction back, address minus one.
// - Both increment and decrement raise instruction error.
// - Via execute: bring and hold, no write-back.
// - Normal indexing and indirection; stack and table combine.
// - Bring sequenced after write-back, before index step.
// - Write-back is first step after instruction fetch.
`timescale 1ns/1ps
module stm_addr_seq
   import stm_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Fetched instruction
   input wire logic ins_start,
   input wire logic [WORD_W-1:0] ins_word,
   input wire logic [ADDR_W-1:0] ins_loc,
   input wire stm_class_type ins_class,
   input wire logic ins_stack_ok,
   input wire logic ins_table_ok,
   input wire logic ins_via_exec,
   // Execution unit
   output logic exec_go,
   output logic [ADDR_W-1:0] exec_addr,
   input wire logic exec_done,
   input wire logic [WORD_W-1:0] hold_data,
   output logic bring_valid,
   output logic [WORD_W-1:0] bring_data,
   output logic seq_done,
   output logic instr_error,
   output logic busy,
   // Core memory
   output stm_mem_type mem,
   input wire logic mem_ack,
   input wire logic [WORD_W-1:0] mem_rdata
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      stm_state_type state;
      logic [WORD_W-1:0] word;
      logic [ADDR_W-1:0] loc;
      stm_class_type cls;
      logic stk_ok;
      logic via_x;
      logic table_op;
      logic stack_op;
      logic [5:0] tog;
      logic err;
      logic [ADDR_W-1:0] disp;
      logic [15:0] rdata;
      stm_mem_type mem;
      logic exec_go;
      logic [ADDR_W-1:0] exec_addr;
      logic bring_valid;
      logic [WORD_W-1:0] bring_data;
      logic seq_done;
      logic instr_error;
      logic busy;
   } stm_regs_type;

   stm_regs_type r;
   stm_regs_type next_r;

   logic [ADDR_W-1:0] sp;
   logic [ADDR_W-1:0] hp;
   logic sp_we;
   logic hp_we;
   logic [ADDR_W-1:0] sp_d;
   logic [ADDR_W-1:0] hp_d;
   logic sp_down;
   logic [ADDR_W-1:0] sp_step;
   logic [ADDR_W-1:0] hp_step;
   logic [ADDR_W-1:0] adr_step;
   logic [ADDR_W-1:0] loc_next;

   // ****************************************
   // Pointer storage and decimal steppers
   // ****************************************
   stm_index_bank u_bank (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ce(ce),
      .sp_we(sp_we),
      .sp_d(sp_d),
      .hp_we(hp_we),
      .hp_d(hp_d),
      .sp(sp),
      .hp(hp)
   );

   // The stack direction depends on the access kind; a bring follows its toggle.
   assign sp_down = (r.state == S_BRING) ? r.tog[TG_DN16] : (r.cls != CLS_STORE);

   stm_step u_sp_step (
      .val(sp),
      .down(sp_down),
      .res(sp_step)
   );

   stm_step u_hp_step (
      .val(hp),
      .down(r.tog[TG_DN17]),
      .res(hp_step)
   );

   stm_step u_adr_step (
      .val(addr_of(r.word)),
      .down(r.word[DEC_BIT]),
      .res(adr_step)
   );

   stm_step u_loc_step (
      .val(r.loc),
      .down(1'b0),
      .res(loc_next)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [5:0] t;
      logic any_opt;
      logic [ADDR_W-1:0] ix;
      t = r.tog;
      any_opt = 1'b0;
      ix = '0;
      next_r = r;
      next_r.exec_go = 1'b0;
      next_r.bring_valid = 1'b0;
      next_r.seq_done = 1'b0;
      next_r.instr_error = 1'b0;
      sp_we = 1'b0;
      hp_we = 1'b0;
      sp_d = sp_step;
      hp_d = hp_step;

      // Register writes. Setting one count toggle drops its partner.
      if (reg_wr && reg_addr == REG_SET) begin
         t = t | reg_wdata[5:0];
         if (reg_wdata[TG_UP16]) t[TG_DN16] = 1'b0;
         if (reg_wdata[TG_DN16]) t[TG_UP16] = 1'b0;
         if (reg_wdata[TG_UP17]) t[TG_DN17] = 1'b0;
         if (reg_wdata[TG_DN17]) t[TG_UP17] = 1'b0;
      end
      if (reg_wr && reg_addr == REG_CLEAR) begin
         t = t & ~reg_wdata[5:0];
      end
      next_r.tog = t;
      if (reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_ERR]) begin
         next_r.err = 1'b0;
      end
      // Software may reload the pointers only while no sequence runs.
      if (reg_wr && reg_addr == REG_SP && r.state == S_IDLE) begin
         sp_we = 1'b1;
         sp_d = reg_wdata;
      end
      if (reg_wr && reg_addr == REG_HP && r.state == S_IDLE) begin
         hp_we = 1'b1;
         hp_d = reg_wdata;
      end

      // Register reads answer in the following cycle.
      if (reg_rd) begin
         case (reg_addr)
            REG_TOGGLES: next_r.rdata = {10'h000, r.tog};
            REG_SP: next_r.rdata = sp;
            REG_HP: next_r.rdata = hp;
            REG_DISPLAY: next_r.rdata = r.disp;
            REG_STATUS: next_r.rdata = {14'h0000, r.err, r.busy};
            default: next_r.rdata = 16'h0000;
         endcase
      end

      case (r.state)
         S_IDLE: begin
            if (ins_start) begin
               any_opt = ins_word[INC_BIT] | ins_word[DEC_BIT]
                  | ins_word[BRING_BIT] | ins_word[HOLD_BIT];
               next_r.word = ins_word;
               next_r.loc = ins_loc;
               next_r.cls = ins_class;
               next_r.stk_ok = ins_stack_ok;
               next_r.via_x = ins_via_exec;
               next_r.table_op = r.tog[TG_TABLE] & ins_table_ok & any_opt;
               next_r.busy = 1'b1;
               if (r.tog[TG_TABLE] && ins_table_ok && ins_word[INC_BIT]
                   && ins_word[DEC_BIT]) begin
                  next_r.instr_error = 1'b1;
                  next_r.err = 1'b1;
                  next_r.state = S_DONE;
               end else if (r.tog[TG_TABLE] && ins_table_ok && !ins_via_exec
                            && (ins_word[INC_BIT] || ins_word[DEC_BIT])) begin
                  next_r.state = S_WBACK;
               end else begin
                  next_r.state = S_IND;
               end
            end
         end
         S_WBACK: begin
            if (!r.mem.req) begin
               next_r.mem = '{req: 1'b1, we: 1'b1, addr: r.loc,
                              wdata: put_addr(r.word, adr_step)};
            end else if (mem_ack) begin
               next_r.mem.req = 1'b0;
               next_r.state = S_IND;
            end
         end
         S_IND: begin
            // Indirect chain first; a table bring closes this step.
            if (r.word[IND_BIT]) begin
               if (!r.mem.req) begin
                  next_r.mem = '{req: 1'b1, we: 1'b0, addr: addr_of(r.word), wdata: '0};
               end else if (mem_ack) begin
                  next_r.mem.req = 1'b0;
                  next_r.word = put_addr(r.word, addr_of(mem_rdata));
                  next_r.word[IND_BIT] = mem_rdata[IND_BIT];
                  next_r.word[XSEL_LO +: XSEL_W] = mem_rdata[XSEL_LO +: XSEL_W];
               end
            end else if (r.table_op && r.word[BRING_BIT]) begin
               next_r.state = S_BRING;
            end else begin
               next_r.state = S_DECIDE;
            end
         end
         S_BRING: begin
            if (!r.mem.req) begin
               next_r.mem = '{req: 1'b1, we: 1'b0, addr: sp, wdata: '0};
            end else if (mem_ack) begin
               next_r.mem.req = 1'b0;
               // The brought word goes straight to the result port, not the secondary register.
               next_r.bring_valid = 1'b1;
               next_r.bring_data = mem_rdata;
               sp_we = r.tog[TG_UP16] | r.tog[TG_DN16];
               next_r.state = S_DECIDE;
            end
         end
         S_DECIDE: begin
            next_r.stack_op = r.tog[TG_STACK] & r.stk_ok & (r.cls != CLS_NONE)
               & (addr_of(r.word) == 16'h0000);
            if (r.tog[TG_STACK] && r.stk_ok && r.cls != CLS_NONE
                && addr_of(r.word) == 16'h0000) begin
               next_r.state = S_EXEC;
               next_r.exec_go = 1'b1;
               if (r.via_x) begin
                  next_r.exec_addr = (r.cls == CLS_STORE) ? r.loc : loc_next;
               end else if (r.cls == CLS_STORE) begin
                  next_r.exec_addr = sp_step;
                  sp_we = 1'b1;
               end else begin
                  next_r.exec_addr = sp;
                  sp_we = 1'b1;
               end
            end else begin
               next_r.state = S_XMOD;
            end
         end
         S_XMOD: begin
            if (r.word[XSEL_LO +: XSEL_W] == XSEL_SP) ix = sp;
            if (r.word[XSEL_LO +: XSEL_W] == XSEL_HP) ix = hp;
            if (r.word[XSEL_LO +: XSEL_W] != XSEL_NONE
                && r.word[XSEL_LO +: XSEL_W] <= XSEL_MEM_MAX) begin
               // Memory index n lives at decimal location n and costs one extra memory cycle.
               if (!r.mem.req) begin
                  next_r.mem = '{req: 1'b1, we: 1'b0, wdata: '0,
                                 addr: bcd_add({11'h000, r.word[XSEL_LO +: XSEL_W]}, 16'h0000)};
               end else if (mem_ack) begin
                  next_r.mem.req = 1'b0;
                  next_r.disp = addr_of(mem_rdata);
                  next_r.exec_addr = bcd_add(addr_of(r.word), addr_of(mem_rdata));
                  next_r.exec_go = 1'b1;
                  next_r.state = S_EXEC;
               end
            end else begin
               if (r.word[XSEL_LO +: XSEL_W] != XSEL_NONE) next_r.disp = ix;
               next_r.exec_addr = bcd_add(addr_of(r.word), ix);
               next_r.exec_go = 1'b1;
               next_r.state = S_EXEC;
            end
         end
         S_EXEC: begin
            if (exec_done) begin
               next_r.state = (r.table_op && r.word[HOLD_BIT]) ? S_HOLD : S_DONE;
            end
         end
         S_HOLD: begin
            if (!r.mem.req) begin
               next_r.mem = '{req: 1'b1, we: 1'b1, addr: hp, wdata: hold_data};
            end else if (mem_ack) begin
               next_r.mem.req = 1'b0;
               hp_we = r.tog[TG_UP17] | r.tog[TG_DN17];
               next_r.state = S_DONE;
            end
         end
         S_DONE: begin
            next_r.seq_done = 1'b1;
            next_r.busy = 1'b0;
            next_r.state = S_IDLE;
         end
         default: begin
            next_r.state = S_IDLE;
            next_r.mem.req = 1'b0;
            next_r.busy = 1'b0;
         end
      endcase
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         r <= '{state: S_IDLE, cls: CLS_NONE, default: '0};
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign reg_rdata = r.rdata;
   assign exec_go = r.exec_go;
   assign exec_addr = r.exec_addr;
   assign bring_valid = r.bring_valid;
   assign bring_data = r.bring_data;
   assign seq_done = r.seq_done;
   assign instr_error = r.instr_error;
   assign busy = r.busy;
   assign mem = r.mem;

endmodule // stm_addr_seq

//--- test/stm_mem_model.sv
// Core memory model that answers the sequencer after a settable latency.
`timescale 1ns/1ps
module stm_mem_model
   import stm_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Request side
   input wire stm_mem_type mem,
   output logic mem_ack,
   output logic [WORD_W-1:0] mem_rdata
);
   logic [WORD_W-1:0] cells [logic [ADDR_W-1:0]];
   logic [ADDR_W-1:0] log_q [$];
   int lat = 1;
   int cnt = 0;
   // Read data flip between answers, so a stale word is never mistaken for a fresh one.
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mem_ack <= 1'b0;
         mem_rdata <= 48'h5a5a_5a5a_5a5a;
         cnt <= 0;
      end else if (mem_ack || !mem.req || cnt < lat) begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         cnt <= (mem_ack || !mem.req) ? 0 : cnt + 1;
      end else begin
         mem_ack <= 1'b1;
         log_q.push_back(mem.addr);
         if (mem.we)
            cells[mem.addr] = mem.wdata;
         else
            mem_rdata <= cells.exists(mem.addr) ? cells[mem.addr] : '0;
      end
   end
endmodule // stm_mem_model

//--- test/stm_addr_seq_assertions.sv
// Port checker for the stack and table address sequencer.
`timescale 1ns/1ps
module stm_addr_seq_assertions
   import stm_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Observed ports
   input wire logic [3:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic ins_start,
   input wire logic [WORD_W-1:0] ins_word,
   input wire logic exec_go,
   input wire logic bring_valid,
   input wire logic seq_done,
   input wire logic instr_error,
   input wire logic busy,
   input wire stm_mem_type mem,
   input wire logic mem_ack
);
   logic [WORD_W-1:0] cap_word;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst)
         cap_word <= '0;
      else if (ins_start && !busy)
         cap_word <= ins_word;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   a_start_busy: assert property (ins_start && !busy |=> busy)
      else $error("start not taken");
   a_err_bits: assert property (instr_error |-> cap_word[INC_BIT] && cap_word[DEC_BIT])
      else $error("error without both step options");
   a_err_quiet: assert property (instr_error |-> (!exec_go && !mem.req) ##1 seq_done)
      else $error("error sequence did work");
   a_req_steady: assert property (mem.req && !mem_ack |=> mem.req && $stable(mem.addr))
      else $error("memory request moved before answer");
   a_req_release: assert property (mem_ack |=> !mem.req)
      else $error("memory request kept after answer");
   a_go_single: assert property (exec_go |=> !exec_go)
      else $error("operand ready longer than one cycle");
   a_done_idle: assert property (seq_done |-> !busy ##1 !seq_done)
      else $error("end of sequence while busy");
   a_read_unmapped: assert property (reg_rd && reg_addr > REG_STATUS |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_bring_word: assert property (bring_valid |-> cap_word[BRING_BIT])
      else $error("bring without bring option");
   c_go: cover property (exec_go);
   c_err: cover property (instr_error);
   c_bring: cover property (bring_valid);
endmodule // stm_addr_seq_assertions

bind stm_addr_seq stm_addr_seq_assertions u_chk (.clk_sys(clk_sys), .nrst(nrst),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ins_start(ins_start),
   .ins_word(ins_word), .exec_go(exec_go), .bring_valid(bring_valid), .seq_done(seq_done),
   .instr_error(instr_error), .busy(busy), .mem(mem), .mem_ack(mem_ack));

//--- test/stm_addr_seq_tb.sv
// Self-checking bench for the stack and table address sequencer.
`timescale 1ns/1ps
module stm_addr_seq_tb
   import stm_pkg::*;
;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic ins_start = 1'b0;
   logic [WORD_W-1:0] ins_word = '0;
   logic [ADDR_W-1:0] ins_loc = '0;
   stm_class_type ins_class = CLS_NONE;
   logic ins_stack_ok = 1'b0;
   logic ins_table_ok = 1'b0;
   logic ins_via_exec = 1'b0;
   logic exec_go, bring_valid, seq_done, instr_error, busy, mem_ack;
   logic exec_done = 1'b0;
   logic [ADDR_W-1:0] exec_addr;
   logic [WORD_W-1:0] hold_data = '0;
   logic [WORD_W-1:0] bring_data, mem_rdata, brought;
   logic [15:0] go_addr;
   logic got_err, got_go;
   stm_mem_type mem;
   int mismatches = 0;
   int num_checks = 0;
   int cyc = 0;
   initial forever #4 clk_sys = ~clk_sys;
   stm_addr_seq u_dut (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ins_start(ins_start), .ins_word(ins_word), .ins_loc(ins_loc), .ins_class(ins_class),
      .ins_stack_ok(ins_stack_ok), .ins_table_ok(ins_table_ok), .ins_via_exec(ins_via_exec),
      .exec_go(exec_go), .exec_addr(exec_addr), .exec_done(exec_done), .hold_data(hold_data),
      .bring_valid(bring_valid), .bring_data(bring_data), .seq_done(seq_done),
      .instr_error(instr_error), .busy(busy), .mem(mem), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));
   stm_mem_model u_mem (.clk_sys(clk_sys), .nrst(nrst), .mem(mem), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));
   // ****************************************
   // Tasks
   // ****************************************
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [47:0] s, input logic [47:0] e);
      num_checks++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task rc(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask
   // Option bits in the order indirect, increment, decrement, bring, hold.
   function automatic logic [47:0] mk(input logic [4:0] o, input logic [4:0] x,
                                      input logic [15:0] a);
      logic [47:0] w;
      w = '0;
      {w[IND_BIT], w[INC_BIT], w[DEC_BIT], w[BRING_BIT], w[HOLD_BIT]} = o;
      w[XSEL_LO +: XSEL_W] = x;
      {w[21:18], w[15:12], w[9:6], w[3:0]} = a;
      return w;
   endfunction
   task run(input logic [47:0] w, input logic [15:0] l, input stm_class_type c,
            input logic s, input logic t, input logic v);
      logic g, done;
      @(posedge clk_sys);
      ins_word <= w;
      ins_loc <= l;
      ins_class <= c;
      ins_stack_ok <= s;
      ins_table_ok <= t;
      ins_via_exec <= v;
      ins_start <= 1'b1;
      @(posedge clk_sys);
      ins_start <= 1'b0;
      {got_err, got_go, brought, go_addr, done} = '0;
      for (int n = 0; n < 300 && !done; n++) begin
         #1;
         if (instr_error === 1'b1)
            got_err = 1'b1;
         if (bring_valid === 1'b1)
            brought = bring_data;
         g = (exec_go === 1'b1);
         if (g)
            go_addr = exec_addr;
         got_go = got_go | g;
         done = (seq_done === 1'b1);
         @(posedge clk_sys);
         exec_done <= g;
      end
      chk(done, 1'b1);
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         stop_test();
      end
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      rc(REG_TOGGLES, 16'h0000);
      rc(REG_SP, PTR_RESET);
      rc(REG_HP, PTR_RESET);
      rc(REG_DISPLAY, 16'h0000);
      rc(4'hf, 16'h0000);
      wr(REG_SET, 16'h0005);
      rc(REG_TOGGLES, 16'h0005);
      wr(REG_SET, 16'h0008);
      rc(REG_TOGGLES, 16'h0009);
      wr(REG_SET, 16'h0010);
      wr(REG_SET, 16'h0020);
      rc(REG_TOGGLES, 16'h0029);
      wr(REG_CLEAR, 16'h003e);
      rc(REG_TOGGLES, 16'h0001);
      $display("test toggles done");
      wr(REG_SP, 16'h0100);
      wr(REG_HP, 16'h0007);
      run(mk(5'h00, XSEL_HP, 16'h0000), 16'h0500, CLS_READ, 1, 0, 0);
      chk(go_addr, 16'h0100);
      rc(REG_SP, 16'h0099);
      run(mk(5'h00, 5'h00, 16'h0000), 16'h0500, CLS_STORE, 1, 0, 0);
      chk(go_addr, 16'h0100);
      run(mk(5'h00, 5'h00, 16'h0250), 16'h0500, CLS_READ, 1, 0, 0);
      chk(go_addr, 16'h0250);
      run(mk(5'h00, 5'h00, 16'h0000), 16'h0500, CLS_READ, 0, 0, 0);
      chk(go_addr, 16'h0000);
      rc(REG_SP, 16'h0100);
      u_mem.cells[16'h0300] = mk(5'h00, 5'h00, 16'h0000);
      run(mk(5'h10, 5'h00, 16'h0300), 16'h0500, CLS_READ, 1, 0, 0);
      chk(go_addr, 16'h0100);
      run(mk(5'h00, 5'h00, 16'h0000), 16'h0500, CLS_EXEC, 1, 0, 0);
      chk(go_addr, 16'h0099);
      rc(REG_SP, 16'h0098);
      run(mk(5'h00, 5'h00, 16'h0000), 16'h0099, CLS_READ, 1, 0, 1);
      chk(go_addr, 16'h0100);
      run(mk(5'h00, 5'h00, 16'h0000), 16'h0099, CLS_STORE, 1, 0, 1);
      chk(go_addr, 16'h0099);
      rc(REG_SP, 16'h0098);
      $display("test stack done");
      wr(REG_CLEAR, 16'h0001);
      u_mem.lat = 3;
      u_mem.cells[16'h0003] = mk(5'h00, 5'h00, 16'h0020);
      run(mk(5'h00, 5'h03, 16'h0180), 16'h0500, CLS_READ, 1, 0, 0);
      chk(go_addr, 16'h0200);
      rc(REG_DISPLAY, 16'h0020);
      $display("test index done");
      wr(REG_SET, 16'h0016);
      wr(REG_SP, 16'h0010);
      wr(REG_HP, 16'h0020);
      u_mem.cells[16'h0010] = 48'h1234_5678_9abc;
      hold_data <= 48'hfedc_ba98_7654;
      u_mem.log_q.delete();
      run(mk(5'h0b, 5'h00, 16'h0400), 16'h0050, CLS_READ, 0, 1, 0);
      chk(brought, 48'h1234_5678_9abc);
      chk(go_addr, 16'h0400);
      chk(u_mem.cells[16'h0020], 48'hfedc_ba98_7654);
      chk(u_mem.cells[16'h0050], mk(5'h0b, 5'h00, 16'h0401));
      chk({u_mem.log_q[0], u_mem.log_q[1], u_mem.log_q[2]}, 48'h0050_0010_0020);
      rc(REG_SP, 16'h0011);
      rc(REG_HP, 16'h0021);
      wr(REG_SET, 16'h0028);
      wr(REG_SP, 16'h0000);
      run(mk(5'h06, 5'h00, 16'h1000), 16'h0060, CLS_READ, 0, 1, 0);
      chk(u_mem.cells[16'h0060], mk(5'h06, 5'h00, 16'h0999));
      rc(REG_SP, 16'h9999);
      u_mem.log_q.delete();
      run(mk(5'h00, 5'h00, 16'h0400), 16'h0070, CLS_READ, 0, 1, 0);
      run(mk(5'h06, 5'h00, 16'h0400), 16'h0070, CLS_READ, 0, 0, 0);
      chk(u_mem.log_q.size(), 0);
      run(mk(5'h0c, 5'h00, 16'h0400), 16'h0080, CLS_READ, 0, 1, 0);
      chk({got_err, got_go}, 2'b10);
      rc(REG_STATUS, 16'h0002);
      wr(REG_STATUS, 16'h0002);
      rc(REG_STATUS, 16'h0000);
      run(mk(5'h0a, 5'h00, 16'h0400), 16'h0090, CLS_READ, 0, 1, 1);
      chk(u_mem.cells.exists(16'h0090), 0);
      rc(REG_SP, 16'h9998);
      $display("test table done");
      stop_test();
   end
endmodule // stm_addr_seq_tb
